//--- core/usrm_pkg.sv
// Purpose: Shared types, constants and route decode for the USB signal route mux
// Assumes: Six-wire transceiver-style signalling per connection (three out, three in)
// Notes:   Route decode is a pure function so the routing stays combinational
package usrm_pkg;

   // Transmit side of a connection, as a transceiver would take it
   typedef struct packed {
      logic oeN;   // Low while the controller drives the line
      logic dat;   // Data, or D+ level in differential style
      logic se0;   // Single-ended zero, or D- level in differential style
   } usrm_tx_t;

   // Receive side of a connection, as a transceiver would give it
   typedef struct packed {
      logic rcv;   // Differential receiver output
      logic vp;    // Single-ended D+ receiver
      logic vm;    // Single-ended D- receiver
   } usrm_rx_t;

   // Source that a pin set carries
   typedef enum logic [3:0] {
      SRC_NONE  = 4'h0,
      SRC_HOST1 = 4'h1,
      SRC_HOST2 = 4'h2,
      SRC_HOST3 = 4'h3,
      SRC_FUNC  = 4'h4,
      SRC_UART  = 4'h5,
      SRC_H3TLL = 4'h6,
      SRC_FTLL  = 4'h7,
      SRC_LOOP  = 4'h8
   } usrm_src_t;

   // Decoded route: three pin sets, differential style flag, internal link flag
   typedef struct packed {
      usrm_src_t xcvr;
      usrm_src_t grp1;
      usrm_src_t grp2;
      logic      diff;
      logic      link;
   } usrm_route_t;

   localparam int       SYNC_STAGES  = 2;
   localparam int       UART_TX_BIT  = 1;
   localparam int       UART_RX_BIT  = 1;
   localparam int       UART_CTS_BIT = 0;
   localparam logic [4:0] MODE_HOSTS = 5'h01;
   localparam logic [4:0] MODE_LOOP  = 5'h07;
   localparam logic [4:0] MODE_RSVD  = 5'h08;
   localparam logic [4:0] MODE_LINK  = 5'h15;
   localparam usrm_tx_t TX_IDLE      = 3'h4;  // Not driving
   localparam usrm_rx_t HOST_IDLE    = 3'h0;  // Pulled-down lines, nothing attached
   localparam usrm_rx_t FUNC_SE0     = 3'h0;  // Both lines low, seen as bus reset
   localparam logic [1:0] LINE_J     = 2'h2;  // Idle full-speed line
   localparam logic [1:0] LINE_SE0   = 2'h0;
   localparam logic [1:0] LINE_K     = 2'h1;
   localparam logic     UART_RX_IDLE = 1'b1;
   localparam logic     UART_CTSN_IDLE = 1'b1;

   // Route table, one entry per route-select value
   function automatic usrm_route_t usrm_decode(input logic [4:0] m);
      usrm_route_t r;
      r = '{SRC_NONE, SRC_NONE, SRC_NONE, 1'b0, 1'b0};
      case (m)
         5'h00: r = '{SRC_FUNC, SRC_NONE, SRC_NONE, 1'b0, 1'b0};
         5'h01: r = '{SRC_HOST1, SRC_HOST2, SRC_HOST3, 1'b0, 1'b0};
         5'h02: r = '{SRC_HOST1, SRC_UART, SRC_HOST3, 1'b0, 1'b0};
         5'h03: r = '{SRC_HOST1, SRC_FUNC, SRC_HOST3, 1'b0, 1'b0};
         5'h04: r = '{SRC_FUNC, SRC_HOST2, SRC_HOST3, 1'b0, 1'b0};
         5'h05: r = '{SRC_HOST1, SRC_NONE, SRC_HOST3, 1'b0, 1'b0};
         5'h06: r = '{SRC_FUNC, SRC_NONE, SRC_HOST3, 1'b0, 1'b0};
         5'h07: r = '{SRC_HOST1, SRC_LOOP, SRC_LOOP, 1'b0, 1'b0};
         5'h09: r = '{SRC_HOST1, SRC_HOST2, SRC_H3TLL, 1'b0, 1'b0};
         5'h0A: r = '{SRC_HOST1, SRC_UART, SRC_H3TLL, 1'b0, 1'b0};
         5'h0B: r = '{SRC_HOST1, SRC_FUNC, SRC_H3TLL, 1'b0, 1'b0};
         5'h0C: r = '{SRC_FUNC, SRC_HOST2, SRC_H3TLL, 1'b0, 1'b0};
         5'h0D: r = '{SRC_HOST1, SRC_NONE, SRC_FTLL, 1'b0, 1'b0};
         5'h0E: r = '{SRC_FUNC, SRC_NONE, SRC_H3TLL, 1'b0, 1'b0};
         5'h0F: r = '{SRC_HOST1, SRC_HOST2, SRC_FTLL, 1'b0, 1'b0};
         5'h10: r = '{SRC_HOST1, SRC_NONE, SRC_NONE, 1'b0, 1'b0};
         5'h11: r = '{SRC_HOST1, SRC_HOST2, SRC_NONE, 1'b0, 1'b0};
         5'h12: r = '{SRC_HOST1, SRC_UART, SRC_NONE, 1'b0, 1'b0};
         5'h13: r = '{SRC_HOST1, SRC_FUNC, SRC_NONE, 1'b0, 1'b0};
         5'h14: r = '{SRC_FUNC, SRC_HOST2, SRC_NONE, 1'b0, 1'b0};
         5'h15: r = '{SRC_HOST1, SRC_NONE, SRC_NONE, 1'b0, 1'b1};
         5'h17: r = '{SRC_HOST1, SRC_HOST2, SRC_H3TLL, 1'b1, 1'b0};
         5'h18: r = '{SRC_HOST1, SRC_UART, SRC_H3TLL, 1'b1, 1'b0};
         5'h19: r = '{SRC_HOST1, SRC_FUNC, SRC_H3TLL, 1'b1, 1'b0};
         default: r = '{SRC_NONE, SRC_NONE, SRC_NONE, 1'b0, 1'b0};
      endcase
      return r;
   endfunction : usrm_decode

   // Line state {dp, dm} one side asks for; bit 2 is set while it drives
   function automatic logic [2:0] usrm_line(input usrm_tx_t t, input logic diff);
      logic [1:0] l;
      l = diff ? {t.dat, t.se0} : (t.se0 ? LINE_SE0 : (t.dat ? LINE_J : LINE_K));
      return {~t.oeN, l};
   endfunction : usrm_line

   // Merge two sides into one line and give the receiver view of it
   function automatic usrm_rx_t usrm_merge(input logic [2:0] a, input logic [2:0] b);
      logic [1:0] l;
      l = a[2] ? a[1:0] : (b[2] ? b[1:0] : LINE_J);
      return '{l[1], l[1], l[0]};
   endfunction : usrm_merge

endpackage : usrm_pkg

//--- core/usrm_signal_route_mux.sv
// Purpose: Route USB host ports, function, serial port one and links onto pin sets
// Assumes: Controllers share core_clk; pin inputs are asynchronous to it
// Notes:   Routing is combinational from the route-select value
// Behaviour
// - Route value 0..31 picks each pin set's source
// - Values 0..7 follow the direct-route table
// - Values 9..15 put transceiverless link on group two
// - Values 16..20 leave group two unconnected
// - Value 21 links host three to function internally
// - Values 23..25 take the on-board chip's link transmit in differential style
// - Values 22, 26..31 connect nothing
// - Serial port one takes group one pins
// - Value 7 loops six inputs to outputs
// - Pinless host port sees no device attached
// - Pinless function sees single-ended zero reset
// - Top-level owned output pin carries top source
// - Top-level owned input pin reads low
// - Link merges both transmit sides into line state
// - The transceiverless link uses six direct logic-level wires
`timescale 1ns/1ps
module usrm_signal_route_mux (
   input  wire  logic                          core_clk,
   input  wire  logic                          sys_rst,
   input  wire  logic [4:0]                    routeModeValue,
   input  wire  usrm_pkg::usrm_tx_t [2:0]      hostTx,
   output       usrm_pkg::usrm_rx_t [2:0]      hostRx,
   input  wire  usrm_pkg::usrm_tx_t            funcTx,
   output       usrm_pkg::usrm_rx_t            funcRx,
   input  wire  logic                          serialOneTx,
   output       logic                          serialOneRx,
   output       logic                          serialOneCtsN,
   output       usrm_pkg::usrm_tx_t            xcvrOut,
   input  wire  usrm_pkg::usrm_rx_t            xcvrIn,
   output       logic [1:0][2:0]               grpOut,
   input  wire  logic [1:0][2:0]               grpIn,
   input  wire  logic [1:0][2:0]               topOutSel,
   input  wire  logic [1:0][2:0]               topOutVal,
   input  wire  logic [1:0][2:0]               topInSel
);
   import usrm_pkg::*;

   logic [1:0][2:0] grpMeta_q;
   logic [1:0][2:0] grpSync_q;
   usrm_rx_t        xcvrMeta_q;
   usrm_rx_t        xcvrSync_q;
   usrm_route_t     route;
   logic [1:0][2:0] grpInM;
   logic [1:0][2:0] grpUsb;
   usrm_tx_t        extTx;
   usrm_tx_t        localTx;
   usrm_rx_t        tllRx;
   usrm_rx_t        linkRx;

   // Two-stage synchronisers on every pin input
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         grpMeta_q  <= '0;
         grpSync_q  <= '0;
         xcvrMeta_q <= '0;
         xcvrSync_q <= '0;
      end else begin
         grpMeta_q  <= grpIn;
         grpSync_q  <= grpMeta_q;
         xcvrMeta_q <= xcvrIn;
         xcvrSync_q <= xcvrMeta_q;
      end
   end

   // Route decode straight from the select value
   assign route = usrm_decode(routeModeValue);

   // Inputs that the top level owns arrive as low
   assign grpInM = grpSync_q & ~topInSel;

   // Transceiverless link on group two: external chip drives our input pins
   assign extTx   = usrm_tx_t'(grpInM[1]);
   assign localTx = (route.grp2 == SRC_H3TLL) ? hostTx[2] : funcTx;
   assign tllRx   = usrm_merge(usrm_line(localTx, 1'b0),
                               usrm_line(extTx, route.diff));

   // Internal host three to function link, no pins involved
   assign linkRx = usrm_merge(usrm_line(hostTx[2], 1'b0),
                              usrm_line(funcTx, 1'b0));

   // Controller receive paths, idle patterns when left without pins
   assign hostRx[0] = (route.xcvr == SRC_HOST1) ? xcvrSync_q : HOST_IDLE;
   assign hostRx[1] = (route.grp1 == SRC_HOST2) ? usrm_rx_t'(grpInM[0]) : HOST_IDLE;
   assign hostRx[2] = (route.grp2 == SRC_HOST3) ? usrm_rx_t'(grpInM[1]) :
                      (route.grp2 == SRC_H3TLL) ? tllRx :
                      route.link ? linkRx : HOST_IDLE;
   assign funcRx    = (route.xcvr == SRC_FUNC) ? xcvrSync_q :
                      (route.grp1 == SRC_FUNC) ? usrm_rx_t'(grpInM[0]) :
                      (route.grp2 == SRC_FTLL) ? tllRx :
                      route.link ? linkRx : FUNC_SE0;

   // Serial port one inputs from group one
   assign serialOneRx   = (route.grp1 == SRC_UART) ? grpInM[0][UART_RX_BIT]
                                                   : UART_RX_IDLE;
   assign serialOneCtsN = (route.grp1 == SRC_UART) ? grpInM[0][UART_CTS_BIT]
                                                   : UART_CTSN_IDLE;

   // Integrated transceiver drive
   assign xcvrOut = (route.xcvr == SRC_HOST1) ? hostTx[0] :
                    (route.xcvr == SRC_FUNC) ? funcTx : TX_IDLE;

   // Group pin drive, then top-level override per pin
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gGroup
         usrm_src_t src;
         assign src = (g == 0) ? route.grp1 : route.grp2;
         assign grpUsb[g] =
            (src == SRC_HOST2) ? 3'(hostTx[1]) :
            (src == SRC_HOST3) ? 3'(hostTx[2]) :
            (src == SRC_FUNC)  ? 3'(funcTx) :
            (src == SRC_UART)  ? {1'b1, serialOneTx, 1'b0} :
            (src == SRC_H3TLL || src == SRC_FTLL) ? 3'(tllRx) :
            (src == SRC_LOOP)  ? grpInM[1-g] :
            3'(TX_IDLE);
         assign grpOut[g] = (topOutSel[g] & topOutVal[g]) |
                            (~topOutSel[g] & grpUsb[g]);
      end
   endgenerate

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence sHeld3(logic [4:0] m);
      (routeModeValue == m && topInSel == '0 && topOutSel == '0)[*3];
   endsequence

   // Synchronised pin paths and static route cases
   a_host1_sync: assert property (sHeld3(MODE_HOSTS) |->
      hostRx[0] == $past(xcvrIn, 2) && xcvrOut == hostTx[0])
      else $error("host port 1 not on transceiver pins after two-stage sync");
   a_loop_path: assert property (sHeld3(MODE_LOOP) |->
      grpOut[1] == $past(grpIn[0], 2) && grpOut[0] == $past(grpIn[1], 2))
      else $error("loopback does not carry group inputs across");
   a_reserved_quiet: assert property ((routeModeValue == MODE_RSVD ||
      routeModeValue == 5'h16 || routeModeValue >= 5'h1A) |->
      xcvrOut == TX_IDLE && grpUsb == {2{3'(TX_IDLE)}} && hostRx == '0)
      else $error("unused route value connects a source");
   a_group2_off: assert property ((routeModeValue >= 5'h10 &&
      routeModeValue <= 5'h14) |-> grpUsb[1] == 3'(TX_IDLE) && hostRx[2] == HOST_IDLE)
      else $error("group two connected in routes 16 to 20");
   a_host_idle: assert property (routeModeValue == 5'h00 |->
      hostRx == '0 && xcvrOut == funcTx)
      else $error("pinless host port does not see idle");
   a_func_reset: assert property ((route.xcvr != SRC_FUNC && route.grp1 != SRC_FUNC &&
      route.grp2 != SRC_FTLL && !route.link) |-> funcRx == FUNC_SE0)
      else $error("pinless function does not see single-ended zero");
   a_uart_pins: assert property (sHeld3(5'h02) |->
      grpOut[0][UART_TX_BIT] == serialOneTx && serialOneRx == $past(grpIn[0][UART_RX_BIT], 2))
      else $error("serial port one not on group one");
   a_top_override: assert property ((topOutSel != '0) |->
      ((grpOut ^ topOutVal) & topOutSel) == '0)
      else $error("top-level owned pin not carrying top source");
   a_input_low: assert property ((routeModeValue == MODE_HOSTS && topInSel[0] == 3'h7) |->
      hostRx[1] == 3'h0)
      else $error("top-level owned input not seen low");
   a_internal_link: assert property ((routeModeValue == MODE_LINK && !hostTx[2].oeN &&
      hostTx[2].se0) |-> funcRx == 3'h0 && grpUsb[1] == 3'(TX_IDLE))
      else $error("internal link does not pass host three reset");
   a_tll_diff: assert property ((routeModeValue == 5'h17 && hostTx[2].oeN &&
      !extTx.oeN) |-> hostRx[2].vp == extTx.dat && hostRx[2].vm == extTx.se0)
      else $error("differential style not used on group two link");

   // Route table views that need no synchroniser
   a_xcvr_func: assert property ((routeModeValue inside {5'h00, 5'h04,
      5'h06, 5'h0C, 5'h0E, 5'h14}) |-> xcvrOut == funcTx)
      else $error("function not on transceiver pins");
   a_grp1_host2: assert property ((topOutSel[0] == '0 && routeModeValue inside
      {5'h01, 5'h04, 5'h09, 5'h0C, 5'h0F, 5'h11, 5'h14, 5'h17}) |-> grpOut[0] == hostTx[1])
      else $error("host port 2 not on group one");
   a_grp1_func: assert property ((topOutSel[0] == '0 && routeModeValue inside
      {5'h03, 5'h0B, 5'h13, 5'h19}) |-> grpOut[0] == funcTx)
      else $error("function not on group one");
   a_grp2_host3: assert property ((topOutSel[1] == '0 && routeModeValue >= 5'h01 &&
      routeModeValue <= 5'h06) |-> grpOut[1] == hostTx[2])
      else $error("host port 3 not on group two");
   a_route_follow: assert property (($changed(routeModeValue) && topOutSel == '0 &&
      routeModeValue == MODE_HOSTS) |-> xcvrOut == hostTx[0] && grpOut[0] == hostTx[1] &&
      grpOut[1] == hostTx[2])
      else $error("route change did not act in the same cycle");

   // Idle views of ports left without pins
   a_serial_idle: assert property (route.grp1 != SRC_UART |->
      serialOneRx && serialOneCtsN)
      else $error("unrouted serial port one inputs not idle");
   a_host2_idle: assert property (route.grp1 != SRC_HOST2 |->
      hostRx[1] == HOST_IDLE)
      else $error("pinless host port 2 does not see idle");
   a_host3_idle: assert property ((route.grp2 != SRC_HOST3 && route.grp2 != SRC_H3TLL &&
      !route.link) |-> hostRx[2] == HOST_IDLE)
      else $error("pinless host port 3 does not see idle");

   // Transceiverless link line state, and group pins left idle by the internal link
   a_tll_local: assert property ((route.grp2 == SRC_H3TLL && !hostTx[2].oeN &&
      hostTx[2].se0) |-> hostRx[2] == 3'h0 && grpUsb[1] == 3'h0)
      else $error("local single-ended zero not on the link");
   a_tll_idle_j: assert property ((route.grp2 == SRC_H3TLL && hostTx[2].oeN &&
      grpInM[1][2]) |-> hostRx[2] == 3'h6)
      else $error("undriven link not seen as idle J");
   a_tll_echo: assert property ((route.grp2 == SRC_H3TLL && topOutSel[1] == '0) |->
      grpOut[1] == hostRx[2])
      else $error("link receiver view not on group two pins");
   a_link_pins: assert property (routeModeValue == MODE_LINK |->
      grpUsb == {2{3'(TX_IDLE)}} && xcvrOut == hostTx[0])
      else $error("internal link route uses group pins");

   // Serial port one drive and clear-to-send
   a_serial_out: assert property ((route.grp1 == SRC_UART && topOutSel[0] == '0) |->
      grpOut[0] == {1'b1, serialOneTx, 1'b0})
      else $error("serial port one transmit not on group one");
   a_serial_cts: assert property (sHeld3(5'h02) |->
      serialOneCtsN == $past(grpIn[0][UART_CTS_BIT], 2))
      else $error("clear-to-send not passed through the synchroniser");

endmodule : usrm_signal_route_mux

//--- tb/usrm_onboard_model.sv
// Purpose: Far side of the pins: on-board chip on the groups, transceiver on xcvr pins
// Assumes: Pins are plain logic levels with no pulls
// Notes:   The bench commands what the on-board chip drives on the group inputs
`timescale 1ns/1ps
module usrm_onboard_model (
   input  wire logic [1:0][2:0]    padDrv,
   input  wire usrm_pkg::usrm_tx_t xcvrOut,
   output      logic [1:0][2:0]    grpIn,
   output      usrm_pkg::usrm_rx_t xcvrIn
);
   import usrm_pkg::*;
   // Six direct wires per link, three of them driven back by the chip
   assign grpIn = padDrv;
   // Transceiver echoes the driven line, idle J when released
   assign xcvrIn = xcvrOut.oeN ? 3'h6 : (xcvrOut.se0 ? 3'h0 : {{2{xcvrOut.dat}}, ~xcvrOut.dat});
endmodule : usrm_onboard_model

//--- tb/test_usb_signal_route_mux.sv
// Purpose: Self-checking bench for the USB signal route mux
// Assumes: Inputs change on the falling edge of core_clk
// Notes:   Expected routes come from the bench's own tables, value 31 leftmost
`timescale 1ns/1ps
module test_usb_signal_route_mux;
   import usrm_pkg::*;
   // Source digit per route value: 0 none, 1-3 hosts, 4 func, 5 serial, F skip
   localparam logic [127:0] XCVR_TBL = 128'h0000_0011_1014_1111_1414_1110_1414_1114;
   localparam logic [127:0] GRP1_TBL = 128'h0000_0045_2002_4520_2002_4520_F002_4520;
   localparam logic [127:0] GRP2_TBL = 128'h0000_00FF_F000_0000_FFFF_FFF0_F333_3330;
   logic                 core_clk;
   logic                 sys_rst;
   logic [4:0]           routeModeValue;
   usrm_tx_t [2:0]       hostTx;
   usrm_rx_t [2:0]       hostRx;
   usrm_tx_t             funcTx;
   usrm_rx_t             funcRx;
   logic                 serialOneTx;
   logic                 serialOneRx;
   logic                 serialOneCtsN;
   usrm_tx_t             xcvrOut;
   usrm_rx_t             xcvrIn;
   logic [1:0][2:0]      grpOut;
   logic [1:0][2:0]      grpIn;
   logic [1:0][2:0]      topOutSel;
   logic [1:0][2:0]      topOutVal;
   logic [1:0][2:0]      topInSel;
   logic [1:0][2:0]      padDrv;
   int                   errorCnt = 0;
   int                   nChecks = 0;

   usrm_signal_route_mux dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
      .routeModeValue(routeModeValue), .hostTx(hostTx), .hostRx(hostRx), .funcTx(funcTx),
      .funcRx(funcRx), .serialOneTx(serialOneTx), .serialOneRx(serialOneRx),
      .serialOneCtsN(serialOneCtsN), .xcvrOut(xcvrOut), .xcvrIn(xcvrIn), .grpOut(grpOut),
      .grpIn(grpIn), .topOutSel(topOutSel), .topOutVal(topOutVal), .topInSel(topInSel));
   usrm_onboard_model boardU (.padDrv(padDrv), .xcvrOut(xcvrOut), .grpIn(grpIn),
      .xcvrIn(xcvrIn));

   // Clock, 50 ns period
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Compare one result, count and report
   task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      nChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Pin pattern a source should put on an output pin set
   function automatic logic [2:0] srcVal(input logic [3:0] s);
      case (s)
         4'h1: return hostTx[0];
         4'h2: return hostTx[1];
         4'h3: return hostTx[2];
         4'h4: return funcTx;
         4'h5: return {1'b1, serialOneTx, 1'b0};
         default: return 3'h4;
      endcase
   endfunction : srcVal

   // Every legal route value against the table, plus idle views of pinless ports
   task automatic test_route_table;
      logic [3:0] x, g1, g2;
      for (int m = 0; m < 32; m++) begin
         if (m == 8) continue;
         @(negedge core_clk);
         routeModeValue = 5'(m);
         #1;
         x = XCVR_TBL[m*4 +: 4];
         g1 = GRP1_TBL[m*4 +: 4];
         g2 = GRP2_TBL[m*4 +: 4];
         chk("xcvrOut", srcVal(x), xcvrOut);
         if (g1 != 4'hF) chk("grpOut1", srcVal(g1), grpOut[0]);
         if (g2 != 4'hF) chk("grpOut2", srcVal(g2), grpOut[1]);
         if (x != 4'h1) chk("hostRx1", HOST_IDLE, hostRx[0]);
         if (g1 != 4'h2 && g1 != 4'hF) chk("hostRx2", HOST_IDLE, hostRx[1]);
         if (x != 4'h4 && g1 != 4'h4 && !(m inside {13, 15, 21}))
            chk("funcRx", FUNC_SE0, funcRx);
         if (g2 == 4'h0 && m != 21) chk("hostRx3", HOST_IDLE, hostRx[2]);
         if (g1 != 4'h5) chk("serialRx", 3'h1, {2'b0, serialOneRx});
         if (g1 != 4'h5) chk("serialCtsN idle", 3'h1, {2'b0, serialOneCtsN});
      end
   endtask : test_route_table

   // Serial input pins and host input through the two-flop synchroniser
   task automatic test_sync_serial;
      @(negedge core_clk);
      routeModeValue = 5'h02;
      padDrv[0] = 3'h0;
      @(negedge core_clk);
      chk("serialRx early", 3'h1, {2'b0, serialOneRx});
      @(negedge core_clk);
      chk("serialRx", 3'h0, {2'b0, serialOneRx});
      chk("serialCtsN", 3'h0, {2'b0, serialOneCtsN});
      serialOneTx = 1'b0;
      @(negedge core_clk);
      chk("serialTx", 3'h4, grpOut[0]);
      serialOneTx = 1'b1;
      routeModeValue = 5'h01;
      padDrv[0] = 3'h5;
      repeat (2) @(negedge core_clk);
      chk("hostRx2", 3'h5, hostRx[1]);
   endtask : test_sync_serial

   // Loopback between the two groups
   task automatic test_loop;
      routeModeValue = 5'h07;
      padDrv = {3'h3, 3'h6};
      repeat (2) @(negedge core_clk);
      chk("loop grpOut2", 3'h6, grpOut[1]);
      chk("loop grpOut1", 3'h3, grpOut[0]);
      chk("loop xcvrOut", 3'h1, xcvrOut);
      hostTx[0] = 3'h2;
      repeat (2) @(negedge core_clk);
      chk("hostRx1", 3'h6, hostRx[0]);
   endtask : test_loop

   // Top-level ownership of output and input pins
   task automatic test_override;
      routeModeValue = 5'h01;
      topOutSel = 6'h3F;
      topOutVal = 6'h2A;
      #1;
      chk("owned grpOut1", 3'h2, grpOut[0]);
      chk("owned grpOut2", 3'h5, grpOut[1]);
      @(negedge core_clk);
      topOutSel = 6'h07;
      topInSel = 6'h07;
      padDrv[0] = 3'h7;
      repeat (2) @(negedge core_clk);
      chk("free grpOut2", 3'h3, grpOut[1]);
      chk("masked hostRx2", 3'h0, hostRx[1]);
      topOutSel = 6'h00;
      topInSel = 6'h00;
   endtask : test_override

   // Transceiverless link, plain and differential, and the internal link
   task automatic test_link;
      routeModeValue = 5'h09;
      padDrv[1] = 3'h7;
      hostTx[2] = 3'h1;
      repeat (2) @(negedge core_clk);
      chk("link grpOut2", 3'h0, grpOut[1]);
      chk("link hostRx3", 3'h0, hostRx[2]);
      hostTx[2] = 3'h4;
      padDrv[1] = 3'h1;
      repeat (2) @(negedge core_clk);
      chk("ext se0 hostRx3", 3'h0, hostRx[2]);
      routeModeValue = 5'h17;
      #1;
      chk("diff hostRx3", 3'h1, hostRx[2]);
      chk("diff grpOut2", 3'h1, grpOut[1]);
      @(negedge core_clk);
      routeModeValue = 5'h15;
      hostTx[2] = 3'h2;
      #1;
      chk("internal funcRx", 3'h6, funcRx);
      @(negedge core_clk);
      hostTx[2] = 3'h1;
      #1;
      chk("internal reset funcRx", 3'h0, funcRx);
      chk("internal grpOut2", 3'h4, grpOut[1]);
      @(negedge core_clk);
   endtask : test_link

   // Counts, verdict and end of run
   task automatic finish_test;
      $display("Checks %0d errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      routeModeValue = 5'h01;
      hostTx = {3'h3, 3'h2, 3'h1};
      funcTx = 3'h0;
      serialOneTx = 1'b1;
      padDrv = {3'h7, 3'h7};
      topOutSel = 6'h00;
      topOutVal = 6'h00;
      topInSel = 6'h00;
      repeat (5) @(negedge core_clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge core_clk);
      test_route_table();
      test_sync_serial();
      test_loop();
      test_override();
      test_link();
      finish_test();
   end

   // Watchdog, well past the sixty or so cycles the run needs
   initial begin
      #100000;
      errorCnt++;
      finish_test();
   end
endmodule : test_usb_signal_route_mux
